//--- logic/adcsf_pkg.sv
// Package with register map, field positions and timing constants of the ADC status flag block.
package adcsf_pkg;

  localparam int unsigned ADDR_W           = 8;
  localparam logic [7:0]  OFF_STATUS       = 8'h00;
  localparam logic [7:0]  OFF_INT_EN       = 8'h04;
  localparam logic [7:0]  OFF_MODE         = 8'h08;
  localparam logic [7:0]  OFF_CUR_CTRL     = 8'h0C;
  localparam logic [7:0]  OFF_FILTER       = 8'h18;
  localparam logic [7:0]  OFF_CUR_RESULT   = 8'h20;
  localparam logic [7:0]  OFF_AUX_RESULT   = 8'h24;
  localparam logic [7:0]  OFF_INT_CLR      = 8'h40;

  localparam int unsigned BIT_TICK         = 12;
  localparam int unsigned BIT_CAL          = 5;
  localparam int unsigned BIT_RSVD         = 4;
  localparam int unsigned BIT_AUX_ERR      = 3;
  localparam int unsigned BIT_CUR_ERR      = 2;
  localparam int unsigned BIT_AUX_RDY      = 1;
  localparam int unsigned BIT_CUR_RDY      = 0;

  localparam logic [15:0] STATUS_RST       = 16'h0000;
  localparam logic [15:0] FILTER_RST       = 16'h0007;
  localparam logic [15:0] MODE_RST         = 16'h0003;
  localparam logic [15:0] CUR_CTRL_RST     = 16'h0000;
  localparam logic [15:0] INT_EN_RST       = 16'h0000;
  localparam logic [15:0] STATUS_MASK      = 16'h102F;

  localparam int unsigned CLK_HZ           = 20000000;
  localparam int unsigned TICK_PERIOD_US   = 1000;
  localparam int unsigned TICK_CYCLES      = CLK_HZ / 1000000 * TICK_PERIOD_US;
  localparam int unsigned TICK_W           = 24;
  localparam int unsigned SETTLE_TICKS     = 2;

endpackage

//--- logic/adcsf_status.sv
// ADC status flag logic with APB register slave and one level interrupt.
//
// Overview of operation
// - Mode, filter or current control write clears calibration
// - Calibration finish sets calibration done flag
// - Aux under or overrange sets aux error
// - Battery above lower threshold sets, upper clears
// - Status read clears aux error flag
// - Current under or overrange sets current error
// - Status read clears current error flag
// - Current result read clears conversion tick
// - Always-interrupt mode ticks each output period
// - Default filter value gives one millisecond period
// - First two ticks after reconfiguration without ready
// - Current channel reconfiguration restarts tick timing
// - Enabled status sources OR into one interrupt
// - Current result read, or aux result read with current control bit 15 clear, clears both ready flags
`timescale 1ns/1ps
module adcsf_status
  import adcsf_pkg::*;
#(
  parameter int unsigned TICK_PERIOD = adcsf_pkg::TICK_CYCLES
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [adcsf_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         cal_done_pulse,
  input  wire logic                         cur_range_err,
  input  wire logic                         aux_range_err,
  input  wire logic                         cur_result_new,
  input  wire logic                         aux_result_new,
  input  wire logic                         vbat_above_low,
  input  wire logic                         vbat_above_high,
  input  wire logic                         always_int_mode,
  input  wire logic                         filter_settled,
  input  wire logic                         aux_enabled,
  output logic      [15:0]                  filter_config,
  output logic      [15:0]                  converter_mode,
  output logic      [15:0]                  current_channel_ctrl,
  output logic                              irq
);
  import adcsf_pkg::*;

  // Battery comparator levels come from the analog side, so they are synchronised.
  logic [1:0] vlow_sync_r;
  logic [1:0] vhigh_sync_r;
  wire        vbat_low_s  = vlow_sync_r[1];
  wire        vbat_high_s = vhigh_sync_r[1];

  logic [15:0] status_r;
  logic [15:0] int_en_r;
  logic [15:0] filter_r;
  logic [15:0] mode_r;
  logic [15:0] cur_ctrl_r;
  logic [31:0] prdata_r;
  logic [1:0]  settle_cnt_r;
  logic        vwin_prev_r;

  wire access    = psel && penable;
  wire wr        = access && pwrite;
  wire rd        = access && !pwrite;
  wire hit_sta   = (paddr == OFF_STATUS);
  wire hit_en    = (paddr == OFF_INT_EN);
  wire hit_mode  = (paddr == OFF_MODE);
  wire hit_cctl  = (paddr == OFF_CUR_CTRL);
  wire hit_flt   = (paddr == OFF_FILTER);
  wire hit_cres  = (paddr == OFF_CUR_RESULT);
  wire hit_ares  = (paddr == OFF_AUX_RESULT);
  wire hit_clr   = (paddr == OFF_INT_CLR);
  wire mapped    = hit_sta | hit_en | hit_mode | hit_cctl | hit_flt | hit_cres | hit_ares
                 | hit_clr;

  wire wr_mode   = wr && hit_mode;
  wire wr_cctl   = wr && hit_cctl;
  wire wr_flt    = wr && hit_flt;
  wire reconfig  = wr_mode || wr_flt || wr_cctl;
  wire rd_status = rd && hit_sta;
  wire rd_cres   = rd && hit_cres;
  wire rd_ares   = rd && hit_ares;
  wire wr_clr    = wr && hit_clr;
  wire [15:0] clr_mask = wr_clr ? pwdata[15:0] : 16'h0000;

  // The timer period scales with the filter word; the default word gives the nominal period.
  wire [TICK_W-1:0] period = TICK_W'((TICK_PERIOD * filter_r) / FILTER_RST);
  wire              tick_raw;

  adcsf_tick_timer #(
    .W (TICK_W)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (reconfig),
    .period  (period),
    .tick    (tick_raw)
  );

  // Outside always-interrupt mode a tick only counts once the filter has settled.
  wire tick      = tick_raw && (always_int_mode || filter_settled);
  wire settling  = (settle_cnt_r != 2'(SETTLE_TICKS));
  // Results are suppressed until two ticks have passed since reconfiguration.
  wire res_ok    = !settling;
  wire cur_new   = cur_result_new && res_ok;
  wire aux_new   = aux_result_new && aux_enabled && res_ok;

  // Entering the window above the lower level is an error event; above the upper level it drops.
  wire vwin      = vbat_low_s && !vbat_high_s;
  wire vwin_rise = vwin && !vwin_prev_r;

  wire rdy_clear = rd_cres || (rd_ares && !current_channel_ctrl[15]);
  wire [15:0] ev;
  assign ev[15:13] = 3'h0;
  assign ev[BIT_TICK]    = tick;
  assign ev[11:6]        = 6'h00;
  assign ev[BIT_CAL]     = cal_done_pulse;
  assign ev[BIT_RSVD]    = 1'b0;
  assign ev[BIT_AUX_ERR] = aux_new && aux_range_err || vwin_rise;
  assign ev[BIT_CUR_ERR] = cur_new && cur_range_err;
  assign ev[BIT_AUX_RDY] = aux_new;
  assign ev[BIT_CUR_RDY] = cur_new;

  // Clear terms are computed per bit; sets are OR'ed in afterwards so a new event wins.
  wire [15:0] clr;
  assign clr[15:13]      = 3'h0;
  assign clr[BIT_TICK]   = rd_cres || reconfig;
  assign clr[11:6]       = 6'h00;
  assign clr[BIT_CAL]    = reconfig;
  assign clr[BIT_RSVD]   = 1'b1;
  // A read clears only the error bits latched into its read word in the setup cycle, so an
  // error that lands between setup and access stays pending for the next read.
  assign clr[BIT_AUX_ERR] = (rd_status && prdata_r[BIT_AUX_ERR]) || reconfig
                          || vbat_high_s;
  assign clr[BIT_CUR_ERR] = (rd_status && prdata_r[BIT_CUR_ERR]) || reconfig;
  assign clr[BIT_AUX_RDY] = rdy_clear || reconfig;
  assign clr[BIT_CUR_RDY] = rdy_clear || reconfig;

  // Software may also clear flags by writing ones to the clear register.
  wire [15:0] status_nxt = ((status_r & ~(clr | clr_mask)) | ev) & STATUS_MASK;

  wire [15:0] rd_word = hit_sta  ? status_r :
                        hit_en   ? int_en_r :
                        hit_mode ? mode_r :
                        hit_cctl ? cur_ctrl_r :
                        hit_flt  ? filter_r : 16'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vlow_sync_r  <= 2'h0;
      vhigh_sync_r <= 2'h0;
      vwin_prev_r  <= 1'b0;
    end else begin
      vlow_sync_r  <= {vlow_sync_r[0], vbat_above_low};
      vhigh_sync_r <= {vhigh_sync_r[0], vbat_above_high};
      vwin_prev_r  <= vwin;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt_r <= 2'h0;
    end else if (reconfig) begin
      settle_cnt_r <= 2'h0;
    end else if (tick && settling) begin
      settle_cnt_r <= settle_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en_r   <= INT_EN_RST;
      filter_r   <= FILTER_RST;
      mode_r     <= MODE_RST;
      cur_ctrl_r <= CUR_CTRL_RST;
    end else begin
      if (wr && hit_en) begin
        int_en_r <= pwdata[15:0] & STATUS_MASK;
      end
      if (wr_flt) begin
        filter_r <= (pwdata[15:0] == 16'h0000) ? FILTER_RST : pwdata[15:0];
      end
      if (wr_mode) begin
        mode_r <= pwdata[15:0];
      end
      if (wr_cctl) begin
        cur_ctrl_r <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= {16'h0000, rd_word};
    end
  end

  // Data is latched in the setup cycle, so every access completes with no wait state.
  assign pready               = 1'b1;
  assign pslverr              = access && !mapped;
  assign prdata               = prdata_r;
  assign filter_config        = filter_r;
  assign converter_mode       = mode_r;
  assign current_channel_ctrl = cur_ctrl_r;
  assign irq                  = |(status_r & int_en_r);

endmodule // adcsf_status

//--- logic/adcsf_tick_timer.sv
// Restartable periodic timer that produces the conversion tick.
`timescale 1ns/1ps
module adcsf_tick_timer #(
  parameter int unsigned W = 24
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         restart,
  input  wire logic [W-1:0] period,
  output logic              tick
);
  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  wire          at_end = (count_r >= period - W'(1));

  assign count_nxt = (restart || at_end) ? '0 : count_r + W'(1);
  assign tick      = at_end && !restart;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end
endmodule // adcsf_tick_timer

//--- verif/adcsf_status_properties.sv
// Port-level checker for the ADC status flag block.
`timescale 1ns/1ps
module adcsf_status_properties
  import adcsf_pkg::*;
(
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [adcsf_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic [31:0]                  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic                         vbat_above_high,
  input wire logic [15:0]                  filter_config,
  input wire logic [15:0]                  converter_mode,
  input wire logic [15:0]                  current_channel_ctrl,
  input wire logic                         irq
);
  wire acc = psel & penable;
  wire wr  = acc & pwrite;
  wire rd  = acc & ~pwrite;
  wire map = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h20, 8'h24, 8'h40};
  wire cfg = wr & (paddr == OFF_MODE || paddr == OFF_CUR_CTRL || paddr == OFF_FILTER);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_high_a: assert property (pready) else $error("pready low");
  unmapped_err_a: assert property (acc |-> pslverr == !map) else $error("pslverr wrong");
  mode_write_a: assert property (wr && paddr == OFF_MODE |=>
    converter_mode == $past(pwdata[15:0])) else $error("mode not written");
  ctrl_write_a: assert property (wr && paddr == OFF_CUR_CTRL |=>
    current_channel_ctrl == $past(pwdata[15:0])) else $error("ctrl not written");
  filter_write_a: assert property (wr && paddr == OFF_FILTER |=> filter_config ==
    ($past(pwdata[15:0]) == 0 ? FILTER_RST : $past(pwdata[15:0]))) else $error("filter");
  reconfig_clear_a: assert property (cfg |=> !irq) else $error("flags kept");
  irq_fall_a: assert property ($fell(irq) |-> $past(acc) ||
    $past(vbat_above_high, 3)) else $error("irq fell alone");
  upper_zero_a: assert property (rd |-> prdata[31:16] == 16'h0000) else $error("upper set");
  status_rsvd_a: assert property (rd && paddr == OFF_STATUS |->
    (prdata[15:0] & ~STATUS_MASK) == 16'h0000) else $error("reserved bits set");
  cover property (cfg);
  cover property ($rose(irq));
  cover property (acc && !map);
endmodule // adcsf_status_properties

bind adcsf_status adcsf_status_properties u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .vbat_above_high(vbat_above_high),
  .filter_config(filter_config),
  .converter_mode(converter_mode), .current_channel_ctrl(current_channel_ctrl), .irq(irq));

//--- verif/adcsf_status_tb.sv
// Self-checking testbench for the ADC status flag block.
`timescale 1ns/1ps
module adcsf_status_tb;
  import adcsf_pkg::*;
  localparam int TP = 20;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, serr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [2:0]        ev;
  logic              cur_err, aux_err, v_lo, v_hi, aim;
  logic [15:0]       flt, mode, ctrl;
  int                num_errors = 0, n_tests = 0, cyc = 0, t0;
  adcsf_status #(.TICK_PERIOD(TP)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cal_done_pulse(ev[0]), .cur_range_err(cur_err),
    .aux_range_err(aux_err), .cur_result_new(ev[1]), .aux_result_new(ev[2]),
    .vbat_above_low(v_lo), .vbat_above_high(v_hi), .always_int_mode(aim),
    .filter_settled(1'b0), .aux_enabled(1'b1), .filter_config(flt), .converter_mode(mode),
    .current_channel_ctrl(ctrl), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Every transfer ends one edge after release, so back-to-back calls never overlap.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic fire(input logic [2:0] v);
    ev <= v;
    @(posedge pclk);
    ev <= 3'h0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge pclk);
  endtask
  task automatic t_reset();
    check({flt, mode, ctrl}, {FILTER_RST, MODE_RST, CUR_CTRL_RST});
    apb(1'b0, OFF_STATUS, 0);
    check(rd, {16'h0000, STATUS_RST});
    apb(1'b0, 8'h7C, 0);
    check({rd, 31'h0, serr}, {32'h0, 31'h0, 1'b1});
    $display("reset test done");
  endtask
  task automatic t_cal();
    logic [7:0] a[3] = '{OFF_MODE, OFF_FILTER, OFF_CUR_CTRL};
    logic [15:0] v[3] = '{MODE_RST, FILTER_RST, CUR_CTRL_RST};
    for (int i = 0; i < 3; i++) begin
      fire(3'h1);
      apb(1'b0, OFF_STATUS, 0);
      check(rd[BIT_CAL], 1'b1);
      apb(1'b1, a[i], {16'h0, v[i]});
      apb(1'b0, OFF_STATUS, 0);
      check(rd, 32'h0);
    end
    $display("calibration test done");
  endtask
  task automatic t_tick();
    apb(1'b1, OFF_INT_EN, 32'h1000);
    apb(1'b1, OFF_MODE, {16'h0, MODE_RST});
    fire(3'h2);
    wait_irq();
    t0 = cyc;
    apb(1'b0, OFF_STATUS, 0);
    check(rd, 32'h1000);
    apb(1'b0, OFF_CUR_RESULT, 0);
    check(irq, 1'b0);
    wait_irq();
    check(cyc - t0, TP);
    cur_err <= 1'b1;
    fire(3'h2);
    apb(1'b0, OFF_STATUS, 0);
    check(rd & 32'hEFFF, 32'h5);
    fork
      apb(1'b0, OFF_STATUS, 0);
      begin
        @(posedge pclk);
        fire(3'h2);
      end
    join
    apb(1'b0, OFF_STATUS, 0);
    check(rd & 32'h000C, 32'h4);
    apb(1'b0, OFF_STATUS, 0);
    check(rd & 32'h000C, 32'h0);
    apb(1'b0, OFF_AUX_RESULT, 0);
    apb(1'b0, OFF_STATUS, 0);
    check(rd & 32'h0003, 32'h0);
    fire(3'h2);
    apb(1'b0, OFF_CUR_RESULT, 0);
    apb(1'b0, OFF_STATUS, 0);
    check(rd & 32'h0003, 32'h0);
    wait_irq();
    aim <= 1'b0;
    apb(1'b1, OFF_INT_CLR, 32'h1000);
    repeat (2 * TP) @(posedge pclk);
    check(irq, 1'b0);
    aim <= 1'b1;
    $display("tick test done");
  endtask
  task automatic t_aux();
    aux_err <= 1'b1;
    fire(3'h4);
    apb(1'b0, OFF_STATUS, 0);
    check(rd & 32'h000A, 32'hA);
    apb(1'b0, OFF_STATUS, 0);
    check(rd & 32'h0008, 32'h0);
    v_lo <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b1, OFF_INT_EN, 32'h0008);
    check(irq, 1'b1);
    apb(1'b1, OFF_INT_EN, 32'h0000);
    check(irq, 1'b0);
    v_hi <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 0);
    check(rd & 32'h0008, 32'h0);
    $display("aux error test done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ev} = '0;
    {cur_err, aux_err, v_lo, v_hi} = '0;
    aim = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_cal();
    t_tick();
    t_aux();
    give_verdict();
  end
  initial begin
    repeat (3000) @(posedge pclk);
    num_errors++;
    give_verdict();
  end
endmodule // adcsf_status_tb
